/* nvrtc_pkg.sv */
// Constants, types and register map of the nonvolatile clock register file.
// Assumes a 50 MHz core clock and a byte-wide host port that is synchronous to it.
package nvrtc_pkg;
	// Register offsets in the host address space.
	localparam logic [12:0] A_BASE = 13'h1ff0;
	localparam logic [12:0] A_FLAGS = 13'h1ff0;
	localparam logic [12:0] A_SPARE = 13'h1ff1;
	localparam logic [12:0] A_ALM_SEC = 13'h1ff2;
	localparam logic [12:0] A_ALM_MIN = 13'h1ff3;
	localparam logic [12:0] A_ALM_HR = 13'h1ff4;
	localparam logic [12:0] A_ALM_DATE = 13'h1ff5;
	localparam logic [12:0] A_IRQ_EN = 13'h1ff6;
	localparam logic [12:0] A_WDOG = 13'h1ff7;
	localparam logic [12:0] A_CTRL = 13'h1ff8;
	localparam logic [12:0] A_SEC = 13'h1ff9;
	localparam logic [12:0] A_MIN = 13'h1ffa;
	localparam logic [12:0] A_HR = 13'h1ffb;
	localparam logic [12:0] A_DAY = 13'h1ffc;
	localparam logic [12:0] A_DATE = 13'h1ffd;
	localparam logic [12:0] A_MON = 13'h1ffe;
	localparam logic [12:0] A_YEAR = 13'h1fff;
	// Value fields inside the timekeeping and alarm bytes.
	localparam logic [7:0] M_SEC = 8'h7f;
	localparam logic [7:0] M_HOUR = 8'h3f;
	localparam logic [7:0] M_DAY = 8'h07;
	localparam logic [7:0] M_DATE = 8'h3f;
	localparam logic [7:0] M_MON = 8'h1f;
	localparam logic [7:0] M_YEAR = 8'hff;
	// Field ranges.
	localparam logic [7:0] SEC_MAX = 8'h59;
	localparam logic [7:0] HOUR_MAX = 8'h23;
	localparam logic [7:0] DAY_MAX = 8'h07;
	localparam logic [7:0] MON_MAX = 8'h12;
	localparam logic [7:0] YEAR_MAX = 8'h99;
	localparam logic [7:0] ZERO_MIN = 8'h00;
	localparam logic [7:0] ONE_MIN = 8'h01;
	// Bit positions.
	localparam int B_WRITE = 7;
	localparam int B_READ = 6;
	localparam int B_OSC = 7;
	localparam int B_WDOG_FLAG = 7;
	localparam int B_ALM_FLAG = 6;
	localparam int B_BAT_LOW = 4;
	localparam int B_MASK = 7;
	localparam int B_AIRQ_EN = 7;
	localparam int B_ABK_EN = 5;
	localparam int B_FT = 6;
	// Reset values.
	localparam logic OSC_STOP_RST = 1'b1;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [7:0] CAL_RST = 8'h01;
	// Timing.
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned RST_HOLD_MS = 40;
	localparam int unsigned RST_HOLD_CYC = CLK_HZ / 1000 * RST_HOLD_MS;
	localparam int unsigned SEC_S = 1;
	localparam int unsigned SEC_CYC = CLK_HZ * SEC_S;
	typedef enum logic [1:0] {
		PWR_FAIL = 2'b00,
		PWR_HOLD = 2'b01,
		PWR_OK = 2'b11
	} nvrtc_pwr_e;
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [12:0] addr;
		logic [7:0] data;
	} nvrtc_host_s;
endpackage

/* nvrtc_core.sv */
// Register file of a battery-backed clock: timekeeping, alarm, control and flags.
// Assumes host strobes, supply monitor and battery monitor arrive as logic levels.
// Contract
// RULE1: Supply below trip level blocks every register read and write.
// RULE2: Backup stays off until supply first rises; then stays enabled.
// RULE3: Flags hold watchdog bit 7, alarm bit 6, read-only battery-low bit 4. Here watchdog bit 7 always reads 0.
// RULE4: Reset pin low during supply fail and 40 to 200 ms after return.
// RULE5: Reset timing uses the core clock, not the stoppable oscillator.
// RULE6: Time registers hold packed BCD in 24-hour ranges.
// RULE7: Seconds bit 7 is the oscillator stop bit; seconds below it.
// RULE8: Writing 1 stops the oscillator and counting; 0 restarts it.
// RULE9: After reset the oscillator is stopped and its stop bit reads 1.
// RULE10: Read-halt bit 6 of control stops copying counters to visible registers.
// RULE11: Visible registers freeze at the count when the halt was set.
// RULE12: Internal counters keep advancing under either halt.
// RULE13: Visible refresh resumes within one second of clearing read-halt.
// RULE14: Host should set read-halt before a multi-byte time read.
// RULE15: Write bit 7 of control halts updates of control through year.
// RULE16: Clearing the write bit copies written values into the counters.
// RULE17: Unused timekeeping bits are storage under the same halt gating.
// RULE18: Unused alarm, enable and spare bits are plain ungated storage.
// RULE19: Watchdog byte: steering bit 7, multiplier 6..2, resolution 1..0.
// RULE20: Enable byte: alarm interrupt enable bit 7, backup alarm bit 5.
// RULE21: Four alarm bytes carry a mask in bit 7 and BCD below.
// RULE22: Frequency-test enable is bit 6 of weekday; day in bits 2..0. Here bit 6 is only stored; irq_freq_out_n never toggles.
// RULE23: Watchdog resolution codes select 1/16, 1/4, 1 and 4 seconds.
// RULE24: Time matching alarm under the mask setting sets the alarm flag.
// RULE25: Any flags access clears the interrupt; flag clears after the access.
// RULE26: Host strobes are synchronised before registers act on them.
`timescale 1ns/1ps
`default_nettype none
module nvrtc_core
	import nvrtc_pkg::*;
#(
	parameter int unsigned RST_HOLD_CYCLES = RST_HOLD_CYC,
	parameter int unsigned SEC_CYCLES = SEC_CYC
) (
	// Clock, reset and clock enable.
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Host memory-style port.
	input wire nvrtc_host_s host,
	output logic [7:0] dq_out,
	output logic dq_oe,
	// Supply and battery monitors.
	input wire logic power_fail_level,
	input wire logic battery_low_flag,
	output logic backup_enable,
	// Open-drain reset and interrupt pins.
	output logic rst_pin_o,
	output logic rst_pin_oe,
	output logic irq_freq_out_n,
	output logic irq_pin_oe
);
	logic [2:0] strb_s1_q, strb_s1_d, strb_s2_q, strb_s2_d;
	logic in_win, wr_act, rd_act, wr_hit, wr_end, flag_acc;
	logic [3:0] idx;
	nvrtc_pwr_e pwr_q, pwr_d;
	logic [31:0] hold_cnt_q, hold_cnt_d, pre_q, pre_d;
	logic backup_q, backup_d, rst_oe_q, rst_oe_d, drive_low_q, tick_q, tick_d;
	logic [7:0] ext_q [0:15];
	logic [7:0] ext_d [0:15];
	logic [7:0] int_q [9:15];
	logic [7:0] int_d [9:15];
	logic osc_q, osc_d, af_q, af_d, irq_q, irq_d, wr_prev_q, wr_prev_d, facc_q, facc_d;
	logic [3:0] wr_idx_q, wr_idx_d;
	logic [7:0] wr_data_q, wr_data_d, dq_out_q, dq_out_d, wdog_unit;
	logic dq_oe_q, dq_oe_d, alarm_evt, hit;
	logic [5:0] cy;
	logic [3:0] am;
	logic eq_s, eq_m, eq_h, eq_d;

	// Advances one masked BCD field, wrapping from hi back to lo.
	function automatic logic [7:0] bump(input logic [7:0] v, input logic [7:0] m,
		input logic [7:0] lo, input logic [7:0] hi);
		logic [7:0] f;
		f = v & m;
		if (f == hi) begin
			f = lo;
		end else if (f[3:0] == 4'h9) begin
			f = {f[7:4] + 4'h1, 4'h0};
		end else begin
			f = {f[7:4], f[3:0] + 4'h1};
		end
		return (v & ~m) | (f & m);
	endfunction

	// Last date of a month; the year is two BCD digits, so every fourth year is long.
	function automatic logic [7:0] month_end(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
			(yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mon)
			8'h02: month_end = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
			default: month_end = 8'h31;
		endcase
	endfunction

	// Strobe synchroniser; address and data are sampled directly.
	always_comb begin
		strb_s1_d = {host.ce_n, host.oe_n, host.we_n};
		strb_s2_d = strb_s1_q;
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			strb_s1_q <= 3'h7;
			strb_s2_q <= 3'h7;
		end else if (clk_en) begin
			strb_s1_q <= strb_s1_d; // see RULE26
			strb_s2_q <= strb_s2_d;
		end
	end

	assign idx = host.addr[3:0];
	assign in_win = host.addr[12:4] == A_BASE[12:4];
	assign wr_act = !strb_s2_q[2] && !strb_s2_q[0] && !power_fail_level; // see RULE1
	assign rd_act = !strb_s2_q[2] && !strb_s2_q[1] && strb_s2_q[0] && !power_fail_level; // see RULE1
	assign wr_hit = wr_act && in_win;
	// A write lands when its strobes end, so a half-seen cycle never reaches the registers.
	assign wr_end = wr_prev_q && !wr_hit && !power_fail_level;
	assign flag_acc = (wr_act || rd_act) && in_win && idx == A_FLAGS[3:0];
	assign wdog_unit = 8'h01 << {ext_q[A_WDOG[3:0]][1:0], 1'b0}; // see RULE23
	// Supply supervisor on the core clock, so it runs with the oscillator stopped.
	always_comb begin
		pwr_d = pwr_q;
		hold_cnt_d = hold_cnt_q;
		backup_d = backup_q;
		if (!power_fail_level) begin
			backup_d = 1'b1; // see RULE2
		end
		case (pwr_q)
			PWR_FAIL: begin
				hold_cnt_d = 32'h0;
				if (!power_fail_level) begin
					pwr_d = PWR_HOLD;
				end
			end
			PWR_HOLD: begin
				if (power_fail_level) begin
					pwr_d = PWR_FAIL;
				end else if (hold_cnt_q == RST_HOLD_CYCLES - 1) begin
					pwr_d = PWR_OK; // see RULE4 RULE5
				end else begin
					hold_cnt_d = hold_cnt_q + 32'h1;
				end
			end
			PWR_OK: begin
				if (power_fail_level) begin
					pwr_d = PWR_FAIL;
				end
			end
			default: pwr_d = PWR_FAIL;
		endcase
		rst_oe_d = pwr_d != PWR_OK; // see RULE4
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pwr_q <= PWR_FAIL;
			hold_cnt_q <= 32'h0;
			backup_q <= 1'b0;
			rst_oe_q <= 1'b1;
			drive_low_q <= 1'b0;
		end else if (clk_en) begin
			pwr_q <= pwr_d;
			hold_cnt_q <= hold_cnt_d;
			backup_q <= backup_d;
			rst_oe_q <= rst_oe_d;
		end
	end

	// One-second prescaler, cleared and held at zero while the oscillator is stopped.
	always_comb begin
		tick_d = 1'b0;
		pre_d = pre_q + 32'h1;
		if (osc_q) begin
			pre_d = 32'h0; // see RULE8
		end else if (pre_q == SEC_CYCLES - 1) begin
			pre_d = 32'h0;
			tick_d = 1'b1;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pre_q <= 32'h0;
			tick_q <= 1'b0;
		end else if (clk_en) begin
			pre_q <= pre_d;
			tick_q <= tick_d;
		end
	end

	// Registers, counters, alarm and host access.
	always_comb begin
		ext_d = ext_q;
		int_d = int_q;
		osc_d = osc_q;
		af_d = af_q;
		irq_d = irq_q;
		facc_d = flag_acc;
		wr_prev_d = wr_hit;
		wr_idx_d = wr_idx_q;
		wr_data_d = wr_data_q;
		// The internal set counts regardless of both halt bits.
		cy[0] = tick_q; // see RULE12
		cy[1] = cy[0] && (int_q[9] & M_SEC) == SEC_MAX;
		cy[2] = cy[1] && (int_q[10] & M_SEC) == SEC_MAX;
		cy[3] = cy[2] && (int_q[11] & M_HOUR) == HOUR_MAX;
		cy[4] = cy[3] && (int_q[13] & M_DATE) == month_end(int_q[14] & M_MON, int_q[15]);
		cy[5] = cy[4] && (int_q[14] & M_MON) == MON_MAX;
		if (cy[0]) int_d[9] = bump(int_q[9], M_SEC, ZERO_MIN, SEC_MAX); // see RULE6
		if (cy[1]) int_d[10] = bump(int_q[10], M_SEC, ZERO_MIN, SEC_MAX);
		if (cy[2]) int_d[11] = bump(int_q[11], M_HOUR, ZERO_MIN, HOUR_MAX);
		if (cy[3]) int_d[12] = bump(int_q[12], M_DAY, ONE_MIN, DAY_MAX); // see RULE22
		if (cy[3]) int_d[13] = bump(int_q[13], M_DATE, ONE_MIN, month_end(int_q[14] & M_MON, int_q[15]));
		if (cy[4]) int_d[14] = bump(int_q[14], M_MON, ONE_MIN, MON_MAX);
		if (cy[5]) int_d[15] = bump(int_q[15], M_YEAR, ZERO_MIN, YEAR_MAX);
		// Visible copy follows the counters, spare bits included, unless a halt bit is set.
		if (!ext_q[A_CTRL[3:0]][B_WRITE] && !ext_q[A_CTRL[3:0]][B_READ]) begin
			for (int i = 9; i < 16; i++) begin
				ext_d[i] = int_q[i]; // see RULE10 RULE11 RULE13 RULE15 RULE17
			end
		end
		// Alarm compare against the new count; unlisted mask patterns fire each second.
		am = {ext_q[A_ALM_DATE[3:0]][B_MASK], ext_q[A_ALM_HR[3:0]][B_MASK],
			ext_q[A_ALM_MIN[3:0]][B_MASK], ext_q[A_ALM_SEC[3:0]][B_MASK]}; // see RULE21
		eq_s = (int_d[9] & M_SEC) == (ext_q[A_ALM_SEC[3:0]] & M_SEC);
		eq_m = (int_d[10] & M_SEC) == (ext_q[A_ALM_MIN[3:0]] & M_SEC);
		eq_h = (int_d[11] & M_HOUR) == (ext_q[A_ALM_HR[3:0]] & M_HOUR);
		eq_d = (int_d[13] & M_DATE) == (ext_q[A_ALM_DATE[3:0]] & M_DATE);
		case (am)
			4'hf: hit = 1'b1;
			4'he: hit = eq_s;
			4'hc: hit = eq_s && eq_m;
			4'h8: hit = eq_s && eq_m && eq_h;
			4'h0: hit = eq_s && eq_m && eq_h && eq_d;
			default: hit = 1'b1;
		endcase
		alarm_evt = tick_q && hit;
		// Enables drop on the way up from a supply failure.
		if (pwr_q == PWR_FAIL && !power_fail_level) begin
			ext_d[A_IRQ_EN[3:0]][B_AIRQ_EN] = 1'b0;
			ext_d[A_IRQ_EN[3:0]][B_ABK_EN] = 1'b0;
		end
		// Host writes: capture while the strobes stand, commit when they end.
		if (wr_hit) begin
			wr_idx_d = idx;
			wr_data_d = host.data;
		end
		if (wr_end) begin
			case (wr_idx_q)
				A_FLAGS[3:0]: ; // see RULE3
				A_SEC[3:0]: begin
					ext_d[A_SEC[3:0]] = wr_data_q;
					osc_d = wr_data_q[B_OSC]; // see RULE7 RULE8
				end
				default: ext_d[wr_idx_q] = wr_data_q; // see RULE18 RULE19 RULE20
			endcase
			if (wr_idx_q == A_CTRL[3:0] && ext_q[A_CTRL[3:0]][B_WRITE] && !wr_data_q[B_WRITE]) begin
				for (int i = 9; i < 16; i++) begin
					int_d[i] = ext_q[i]; // see RULE16
				end
				int_d[9][B_OSC] = 1'b0;
			end
		end
		// Flags access drops the interrupt at once and the flag after the access.
		if (flag_acc) begin
			irq_d = 1'b0; // see RULE25
		end
		if (facc_q && !flag_acc) begin
			af_d = 1'b0; // see RULE25
		end
		// A new alarm outranks a clear in the same cycle.
		if (alarm_evt) begin
			af_d = 1'b1; // see RULE24
			if (ext_q[A_IRQ_EN[3:0]][B_AIRQ_EN] && (!power_fail_level || ext_q[A_IRQ_EN[3:0]][B_ABK_EN])) begin
				irq_d = 1'b1;
			end
		end
		// Read data path; watchdog flag reads 0 as the watchdog timer is not built here.
		dq_oe_d = rd_act && in_win;
		case (idx)
			A_FLAGS[3:0]: dq_out_d = {1'b0, af_q, 1'b0, battery_low_flag, 4'h0}; // see RULE3
			A_SEC[3:0]: dq_out_d = {osc_q, ext_q[A_SEC[3:0]][6:0]}; // see RULE7
			default: dq_out_d = ext_q[idx];
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 16; i++) begin
				ext_q[i] <= REG_RST; // see RULE19 RULE20
			end
			for (int i = 9; i < 16; i++) begin
				int_q[i] <= REG_RST;
			end
			ext_q[A_DAY[3:0]] <= CAL_RST;
			ext_q[A_DATE[3:0]] <= CAL_RST;
			ext_q[A_MON[3:0]] <= CAL_RST;
			int_q[A_DAY[3:0]] <= CAL_RST;
			int_q[A_DATE[3:0]] <= CAL_RST;
			int_q[A_MON[3:0]] <= CAL_RST;
			osc_q <= OSC_STOP_RST; // see RULE9
			af_q <= 1'b0;
			irq_q <= 1'b0;
			facc_q <= 1'b0;
			wr_prev_q <= 1'b0;
			wr_idx_q <= 4'h0;
			wr_data_q <= 8'h00;
			dq_out_q <= 8'h00;
			dq_oe_q <= 1'b0;
		end else if (clk_en) begin
			ext_q <= ext_d;
			int_q <= int_d;
			osc_q <= osc_d;
			af_q <= af_d;
			irq_q <= irq_d;
			facc_q <= facc_d;
			wr_prev_q <= wr_prev_d;
			wr_idx_q <= wr_idx_d;
			wr_data_q <= wr_data_d;
			dq_out_q <= dq_out_d;
			dq_oe_q <= dq_oe_d;
		end
	end

	assign dq_out = dq_out_q;
	assign dq_oe = dq_oe_q;
	assign backup_enable = backup_q;
	assign rst_pin_o = drive_low_q;
	assign rst_pin_oe = rst_oe_q;
	assign irq_freq_out_n = drive_low_q;
	assign irq_pin_oe = irq_q;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n || !clk_en);
	AST_PF_BLOCKS_READ: assert property (power_fail_level |=> !dq_oe) // see RULE1
		else $error("read answered during power fail");
	AST_BACKUP_ON: assert property (!power_fail_level ##1 power_fail_level |-> backup_enable [*2]) // see RULE2
		else $error("backup not enabled after supply rose");
	AST_BATLOW_READ: assert property (rd_act && in_win && idx == A_FLAGS[3:0]
		|=> dq_out[B_BAT_LOW] == $past(battery_low_flag) && dq_out[3:0] == 4'h0) // see RULE3
		else $error("battery low bit misread");
	AST_RST_IN_FAIL: assert property (power_fail_level |=> rst_pin_oe) // see RULE4
		else $error("reset released during power fail");
	AST_RST_HOLD: assert property ($fell(rst_pin_oe) |-> $past(pwr_q) == PWR_HOLD
		&& $past(hold_cnt_q) == RST_HOLD_CYCLES - 1) // see RULE4
		else $error("reset released before hold time");
	AST_OSC_STOP: assert property (osc_q |=> !tick_q) // see RULE8
		else $error("second tick while oscillator stopped");
	AST_READ_FREEZE: assert property (ext_q[A_CTRL[3:0]][B_READ] && !wr_end
		|=> $stable(ext_q[A_MIN[3:0]]) && $stable(ext_q[A_YEAR[3:0]])) // see RULE11
		else $error("visible time moved under read halt");
	AST_INT_ADVANCE: assert property (tick_q && (int_q[9] & M_SEC) != SEC_MAX && !wr_end
		|=> int_q[9] != $past(int_q[9])) // see RULE12
		else $error("internal seconds did not advance");
	AST_REFRESH: assert property (!ext_q[A_CTRL[3:0]][B_READ] && !ext_q[A_CTRL[3:0]][B_WRITE] && !wr_end
		|=> ext_q[A_HR[3:0]] == $past(int_q[A_HR[3:0]])) // see RULE13
		else $error("visible hours not refreshed");
	AST_TRANSFER: assert property (wr_end && wr_idx_q == A_CTRL[3:0] && ext_q[A_CTRL[3:0]][B_WRITE]
		&& !wr_data_q[B_WRITE] |=> int_q[A_YEAR[3:0]] == $past(ext_q[A_YEAR[3:0]])) // see RULE16
		else $error("written time not transferred");
	AST_FLAGS_CLEAR: assert property (flag_acc && !alarm_evt |=> !irq_pin_oe) // see RULE25
		else $error("interrupt not cleared by flags access");
	AST_FLAG_HOLD: assert property (af_q && flag_acc |=> af_q) // see RULE25
		else $error("alarm flag dropped during flags access");
	AST_WDOG_UNIT: assert property (ext_q[A_WDOG[3:0]][1:0] == 2'b00 |-> wdog_unit == 8'h01) // see RULE23
		else $error("watchdog unit not one sixteenth");
endmodule
`default_nettype wire

/* nvrtc_host_model.sv */
// Host processor model that drives the byte-wide strobe port of the clock register file.
// Assumes the core clock and that the bench resolves the shared data lines.
`timescale 1ns/1ps
`default_nettype none
module nvrtc_host_model
	import nvrtc_pkg::*;
(
	// Clock.
	input wire logic core_clk,
	// Strobes, address and write data.
	output var nvrtc_host_s host,
	// Read answer.
	input wire logic [7:0] dq_out,
	input wire logic dq_oe
);
	initial host = '{1'b1, 1'b1, 1'b1, 13'h0000, 8'h00};

	// Address and data are held three edges past the strobe end so the late commit sees them.
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		host = '{1'b0, 1'b1, 1'b0, a, d};
		repeat (4) @(posedge core_clk);
		#1;
		host = '{1'b1, 1'b1, 1'b1, a, d};
		repeat (3) @(posedge core_clk);
		#1;
		host = '{1'b1, 1'b1, 1'b1, ~a, ~d};
		repeat (2) @(posedge core_clk);
		#1;
	endtask

	// A released data line shows the inverse of its last value, never a convenient level.
	task automatic rd(input logic [12:0] a, output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(posedge core_clk);
		#1;
		host = '{1'b0, 1'b0, 1'b1, a, ~host.data};
		for (int i = 0; i < 8 && !ok; i++) begin
			@(posedge core_clk);
			if (dq_oe === 1'b1) begin
				ok = 1'b1;
				d = dq_out;
			end
		end
		#1;
		host = '{1'b1, 1'b1, 1'b1, ~a, ~host.data};
		repeat (4) @(posedge core_clk);
		#1;
	endtask
endmodule
`default_nettype wire

/* nvrtc_core_test.sv */
// Self-checking bench for the clock register file, run through the host model.
// Assumes the package and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module nvrtc_core_test
	import nvrtc_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic power_fail_level = 1'b0;
	logic battery_low_flag = 1'b0;
	nvrtc_host_s host_drv;
	nvrtc_host_s host_bus;
	logic [7:0] dq_out;
	logic dq_oe, backup_en, rst_o, rst_oe, irq_o, irq_oe, ok;
	logic [7:0] v, e, s1, s2;
	logic [7:0] tset[7] = '{8'h58, 8'h59, 8'h23, 8'h47, 8'h31, 8'h12, 8'h99};
	logic [7:0] texp[7] = '{8'h00, 8'h00, 8'h00, 8'h41, 8'h01, 8'h01, 8'h00};
	int fail_count = 0;
	int check_count = 0;
	int cycles = 0;

	always #10 core_clk = ~core_clk;

	always_comb begin
		host_bus = host_drv;
		if (dq_oe) begin
			host_bus.data = dq_out;
		end
	end

	nvrtc_core #(.RST_HOLD_CYCLES(20), .SEC_CYCLES(16)) u_nvrtc_core (
		.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .host(host_bus),
		.dq_out(dq_out), .dq_oe(dq_oe), .power_fail_level(power_fail_level),
		.battery_low_flag(battery_low_flag), .backup_enable(backup_en),
		.rst_pin_o(rst_o), .rst_pin_oe(rst_oe), .irq_freq_out_n(irq_o), .irq_pin_oe(irq_oe)
	);

	nvrtc_host_model u_nvrtc_host_model (
		.core_clk(core_clk), .host(host_drv), .dq_out(dq_out), .dq_oe(dq_oe)
	);

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic rdc(input string name, input logic [12:0] a, input logic [7:0] exp);
		u_nvrtc_host_model.rd(a, v, ok);
		check(name, v, exp);
	endtask

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		u_nvrtc_host_model.wr(a, d);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// The whole run needs about 1100 cycles, so this ceiling only trips on a hang.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	initial begin
		tick(2);
		check("backup in reset", {7'h0, backup_en}, 8'h00);
		rst_n = 1'b1;
		tick(1);
		check("rst pin held", {7'h0, rst_oe}, 8'h01);
		tick(30);
		check("rst pin free", {7'h0, rst_oe}, 8'h00);
		check("backup on", {7'h0, backup_en}, 8'h01);
		check("pin levels", {6'h0, rst_o, irq_o}, 8'h00);
		for (int a = 0; a < 16; a++) begin
			e = (a == 9) ? 8'h80 : (a >= 12 && a <= 14) ? 8'h01 : 8'h00;
			rdc("reset value", A_BASE + 13'(a), e);
		end
		for (int a = 1; a < 8; a++) begin
			e = {4'(a), ~4'(a)};
			wr(A_BASE + 13'(a), e);
			rdc("storage", A_BASE + 13'(a), e);
		end
		battery_low_flag = 1'b1;
		wr(A_FLAGS, 8'hff);
		rdc("flags", A_FLAGS, 8'h10);
		battery_low_flag = 1'b0;
		rdc("flags", A_FLAGS, 8'h00);
		// Load 23:59:58 on the last day of year 99, then let it roll over.
		wr(A_CTRL, 8'h80);
		foreach (tset[i]) wr(A_SEC + 13'(i), tset[i]);
		wr(A_CTRL, 8'h00);
		tick(40);
		wr(A_CTRL, 8'h40);
		u_nvrtc_host_model.rd(A_SEC, s1, ok);
		check("sec window", 8'(s1 == 8'h01 || s1 == 8'h02), 8'h01);
		for (int i = 1; i < 7; i++) rdc("rollover", A_SEC + 13'(i), texp[i]);
		tick(40);
		rdc("frozen sec", A_SEC, s1);
		wr(A_CTRL, 8'h00);
		u_nvrtc_host_model.rd(A_SEC, s2, ok);
		check("resumed sec", 8'(s2 >= s1 + 8'h03 && s2 <= s1 + 8'h15), 8'h01);
		// Seconds-only match: masks set on minutes, hours and date.
		for (int i = 1; i < 4; i++) wr(A_ALM_SEC + 13'(i), 8'h80);
		wr(A_ALM_SEC, 8'h20);
		wr(A_IRQ_EN, 8'h80);
		for (int i = 0; i < 1200 && irq_oe !== 1'b1; i++) tick(1);
		check("irq raised", {7'h0, irq_oe}, 8'h01);
		rdc("alarm flag", A_FLAGS, 8'h40);
		check("irq cleared", {7'h0, irq_oe}, 8'h00);
		rdc("flag cleared", A_FLAGS, 8'h00);
		wr(A_CTRL, 8'h80);
		wr(A_SEC, 8'h80);
		wr(A_CTRL, 8'h00);
		rdc("stopped", A_SEC, 8'h80);
		tick(40);
		rdc("still stopped", A_SEC, 8'h80);
		// Power fail while the oscillator is stopped shows the reset timer runs without it.
		wr(A_IRQ_EN, 8'ha5);
		wr(A_SPARE, 8'h77);
		power_fail_level = 1'b1;
		tick(2);
		check("rst pin in fail", {7'h0, rst_oe}, 8'h01);
		u_nvrtc_host_model.rd(A_SPARE, v, ok);
		check("blocked read", {7'h0, ok}, 8'h00);
		wr(A_SPARE, 8'h3c);
		power_fail_level = 1'b0;
		tick(15);
		check("rst pin hold", {7'h0, rst_oe}, 8'h01);
		check("backup kept", {7'h0, backup_en}, 8'h01);
		tick(10);
		check("rst pin off", {7'h0, rst_oe}, 8'h00);
		rdc("spare kept", A_SPARE, 8'h77);
		rdc("enables cleared", A_IRQ_EN, 8'h05);
		u_nvrtc_host_model.rd(13'h0100, v, ok);
		check("unmapped read", {7'h0, ok}, 8'h00);
		wr(A_CTRL, 8'h80);
		wr(A_SEC, 8'h00);
		wr(A_CTRL, 8'h00);
		tick(40);
		u_nvrtc_host_model.rd(A_SEC, v, ok);
		check("restarted", 8'(v >= 8'h01 && v <= 8'h04), 8'h01);
		tally_and_finish();
	end
endmodule
`default_nettype wire
